// ===== design/emu_port_pkg.sv
/*
 * Shared constants and types for the emulation memory bus port: register
 * offsets and reset values, access kinds, bus phases and the packed
 * carriers for pins, core requests and emulator accesses.
 * Assumes a single clock domain and an AXI4-Lite register bus.
 */
package emu_port_pkg;

	// Register offsets inside the low nibble of the AXI byte address.
	localparam logic [3:0] OFF_EXT_ADDR = 4'h0;
	localparam logic [3:0] OFF_PAGE = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;

	// Field positions and reset values.
	localparam int EXT_CS_MODE_BIT = 7;
	localparam logic [7:0] EXT_ADDR_RESET = 8'h00;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	// High address mask for the largest ROM code; smaller codes shift it.
	localparam logic [7:0] STD_HIGH_MASK_MAX = 8'h7f;
	localparam logic [1:0] STD_CODE_MAX = 2'h3;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ACC_FETCH, ACC_MOVC, ACC_DPTR_RD, ACC_DPTR_WR, ACC_RI_RD, ACC_RI_WR
	} acc_kind_t;

	typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} phase_t;

	typedef struct packed {
		logic valid;
		acc_kind_t kind;
		logic [15:0] addr;
		logic [7:0] wdata;
	} core_req_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic target;
		logic [7:0] addr;
		logic [7:0] wdata;
	} emu_acc_t;

	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} pins8_t;

	typedef struct packed {
		logic [3:0] o;
		logic [3:0] oe;
	} pins4_t;

	typedef struct packed {
		logic strap_done;
		logic type_std;
		logic [7:0] ext_addr;
		logic [7:0] page;
		logic [7:0] p3;
		phase_t phase;
		logic busy;
		core_req_t req;
		logic [1:0] rom_code;
		logic done;
		logic [7:0] rdata;
		logic wr_q;
		logic rd_q;
		emu_acc_t emu;
		pins8_t data;
		pins8_t low;
		pins8_t high;
		pins4_t upper;
		logic awready;
		logic wready;
		logic aw_hold;
		logic [2:0] aw_sel;
		logic w_hold;
		logic [7:0] w_data;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] axi_rdata;
	} state_t;

	// Enum members are named so that no zero is forced into an enum.
	localparam state_t ST_RESET = '{awready: 1'b1, wready: 1'b1,
		arready: 1'b1, phase: PH_IDLE,
		req: '{kind: ACC_FETCH, default: '0}, default: '0};

endpackage

// ===== design/emu_bus_port.sv
/*
 * Pin-function logic of the dedicated external memory bus of an emulation
 * controller: normal-mode address/data multiplexing for both types, chip
 * selects and extended address, and the emulator parallel access port.
 * Assumes all inputs synchronous to REF_CLK_IN and a core that presents one
 * memory request at a time and answers emulator reads combinationally.
 */
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Port 3 frozen during emulation.
// - Advanced data pins multiplex low address/data.
// - Emulation data pins carry access data, emulation_select floats.
// - ROM size code selects served EPROM size.
// - Advanced low pins output address bits 7:0.
// - Emulator drives low address, emulation_select high floats.
// - High pins address 15:8, page register for Ri.
// - High bit 0 selects registers or RAM.
// - Standard high pins drive size-dependent bits.
// - Standard low pins drive address 7:0.
// - Upper pins carry extended address or zero.
// - Upper pins become one-hot low chip selects.
// - Emulator write/read strobes on upper pins.
// - Upper pin 2 shows program path.
// - Upper pin 3 low enables program store.
// - Type strap low selects standard type.
module emu_bus_port import emu_port_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// Clock, reset and clock enable.
	input wire logic REF_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	// Straps and mode inputs.
	input wire logic TYPE_SELECT_N_IN,
	input wire logic ROM_SIZE_SEL_HI_IN,
	input wire logic ROM_SIZE_SEL_LO_IN,
	input wire logic EMULATION_MODE_IN,
	input wire logic EMULATION_SELECT_IN,
	// Core side.
	input wire core_req_t CORE_REQ_IN,
	output logic [7:0] CORE_RDATA_OUT,
	output logic CORE_DONE_OUT,
	output logic CORE_BUSY_OUT,
	input wire logic [7:0] PORT3_CORE_IN,
	output logic [7:0] PORT3_OUT,
	output emu_acc_t EMU_ACC_OUT,
	input wire logic [7:0] EMU_RDATA_IN,
	// Bus pins.
	input wire logic [7:0] MUX_DATA_BUS_IN,
	output logic [7:0] MUX_DATA_BUS_OUT,
	output logic [7:0] MUX_DATA_BUS_OE_OUT,
	input wire logic [7:0] LOW_ADDRESS_BUS_IN,
	output logic [7:0] LOW_ADDRESS_BUS_OUT,
	output logic [7:0] LOW_ADDRESS_BUS_OE_OUT,
	input wire logic [7:0] HIGH_ADDRESS_BUS_IN,
	output logic [7:0] HIGH_ADDRESS_BUS_OUT,
	output logic [7:0] HIGH_ADDRESS_BUS_OE_OUT,
	input wire logic [3:0] UPPER_ADDRESS_PINS_IN,
	output logic [3:0] UPPER_ADDRESS_PINS_OUT,
	output logic [3:0] UPPER_ADDRESS_PINS_OE_OUT,
	// AXI4-Lite slave.
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);

	// The decoder needs the whole register nibble.
	if (ADDR_W < 4) begin : g_bad_width
		$error("ADDR_W must be at least 4");
	end

	state_t st;
	state_t next_st;
	logic [1:0] rom_code;
	logic [7:0] std_mask;
	logic [7:0] status;

	// Returns {mapped, index}; index 0 ext, 1 page, 2 status.
	function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
		logic [2:0] r;
		r = 3'h0;
		if ((a >> 4) == '0) begin
			case (a[3:0])
				OFF_EXT_ADDR: r = 3'h4;
				OFF_PAGE: r = 3'h5;
				OFF_STATUS: r = 3'h6;
				default: r = 3'h0;
			endcase
		end
		return r;
	endfunction

	function automatic logic is_code(input acc_kind_t k);
		return (k == ACC_FETCH) || (k == ACC_MOVC);
	endfunction

	function automatic logic is_ri(input acc_kind_t k);
		return (k == ACC_RI_RD) || (k == ACC_RI_WR);
	endfunction

	function automatic logic is_write(input acc_kind_t k);
		return (k == ACC_DPTR_WR) || (k == ACC_RI_WR);
	endfunction

	// Size code and the high-byte mask it implies.
	assign rom_code = {ROM_SIZE_SEL_HI_IN, ROM_SIZE_SEL_LO_IN};
	assign std_mask = STD_HIGH_MASK_MAX >> (STD_CODE_MAX - rom_code);
	assign status = {2'h0, EMULATION_SELECT_IN, st.phase != PH_IDLE,
		rom_code, st.type_std, EMULATION_MODE_IN};

	// Next-state logic for the pins, the access phases and the bus slave.
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.emu.wr = 1'b0;
		next_st.emu.rd = 1'b0;
		// The strap is caught once, after reset is released.
		if (!st.strap_done) begin
			next_st.strap_done = 1'b1;
			next_st.type_std = !TYPE_SELECT_N_IN;
		end
		// Outside emulation Port 3 follows the core; inside it holds.
		if (!EMULATION_MODE_IN) begin
			next_st.p3 = PORT3_CORE_IN;
		end
		if (EMULATION_MODE_IN) begin
			// An access cut by emulation entry is dropped without done.
			next_st.phase = PH_IDLE;
			next_st.low.oe = 8'h00;
			next_st.high.oe = 8'h00;
			next_st.upper.oe = 4'h0;
			next_st.data.o = EMU_RDATA_IN;
			if (EMULATION_SELECT_IN) begin
				next_st.data.oe = 8'h00;
				next_st.wr_q = 1'b0;
				next_st.rd_q = 1'b0;
			end else begin
				// Strobes are levels; the core sees one pulse per rising edge.
				next_st.wr_q = UPPER_ADDRESS_PINS_IN[0];
				next_st.rd_q = UPPER_ADDRESS_PINS_IN[1];
				next_st.emu.wr = UPPER_ADDRESS_PINS_IN[0] && !st.wr_q;
				next_st.emu.rd = UPPER_ADDRESS_PINS_IN[1] && !st.rd_q;
				next_st.emu.addr = LOW_ADDRESS_BUS_IN;
				next_st.emu.target = HIGH_ADDRESS_BUS_IN[0];
				next_st.emu.wdata = MUX_DATA_BUS_IN;
				// Drive only under the read strobe to avoid bus fights.
				next_st.data.oe = UPPER_ADDRESS_PINS_IN[1] ? 8'hff : 8'h00;
			end
		end else begin
			next_st.wr_q = 1'b0;
			next_st.rd_q = 1'b0;
			unique case (st.phase)
				PH_IDLE: begin
					next_st.data.oe = 8'h00;
					next_st.upper.oe = st.type_std ? 4'hc : 4'hf;
					next_st.upper.o[3] = st.type_std ? 1'b1 : st.upper.o[3];
					next_st.low.oe = 8'hff;
					next_st.high.oe = st.type_std ? std_mask : 8'hff;
					if (!st.type_std && !st.ext_addr[EXT_CS_MODE_BIT]) begin
						next_st.upper.o = 4'h0;
					end
					if (CORE_REQ_IN.valid) begin
						next_st.req = CORE_REQ_IN;
						next_st.rom_code = rom_code;
						next_st.low.o = CORE_REQ_IN.addr[7:0];
						next_st.data.o = CORE_REQ_IN.addr[7:0];
						next_st.data.oe = 8'hff;
						next_st.phase = PH_ADDR;
						if (st.type_std) begin
							next_st.high.o = CORE_REQ_IN.addr[15:8] & std_mask;
							next_st.upper.o = 4'h8;
							// Data accesses and code outside the served size: Port 0/2 carry them.
							if (!is_code(CORE_REQ_IN.kind) ||
								((CORE_REQ_IN.addr[15:8] & ~std_mask) != 8'h00)) begin
								next_st.upper.o[2] = 1'b1;
								next_st.data.oe = 8'h00;
								next_st.done = 1'b1;
								next_st.rdata = 8'h00;
								next_st.phase = PH_IDLE;
							end
						end else begin
							next_st.high.o = is_ri(CORE_REQ_IN.kind) ?
								st.page : CORE_REQ_IN.addr[15:8];
							if (st.ext_addr[EXT_CS_MODE_BIT]) begin
								next_st.upper.o = ~(4'h1 << (is_ri(CORE_REQ_IN.kind) ?
									st.page[7:6] : CORE_REQ_IN.addr[15:14]));
							end else if (!is_ri(CORE_REQ_IN.kind) &&
								CORE_REQ_IN.kind != ACC_FETCH) begin
								next_st.upper.o = st.ext_addr[3:0];
							end else begin
								next_st.upper.o = 4'h0;
							end
						end
					end
				end
				PH_ADDR: begin
					next_st.phase = PH_DATA;
					next_st.data.o = st.req.wdata;
					next_st.data.oe = is_write(st.req.kind) ? 8'hff : 8'h00;
					if (st.type_std) begin
						next_st.upper.o[3] = 1'b0;
					end
				end
				PH_DATA: begin
					next_st.phase = PH_IDLE;
					next_st.data.oe = 8'h00;
					next_st.rdata = MUX_DATA_BUS_IN;
					next_st.done = 1'b1;
					if (st.type_std) begin
						next_st.upper.o[3] = 1'b1;
					end
				end
				default: next_st.phase = PH_IDLE;
			endcase
		end
		next_st.busy = next_st.phase != PH_IDLE; // Registered busy flag.
		// Write address and write data are taken in either order.
		if (st.awready && S_AXI_AWVALID) begin
			next_st.awready = 1'b0;
			next_st.aw_hold = 1'b1;
			next_st.aw_sel = decode(S_AXI_AWADDR);
		end
		if (st.wready && S_AXI_WVALID) begin
			next_st.wready = 1'b0;
			next_st.w_hold = 1'b1;
			next_st.w_data = S_AXI_WDATA[7:0];
			next_st.w_lane = S_AXI_WSTRB[0];
		end
		if (st.aw_hold && st.w_hold && !st.bvalid) begin
			next_st.aw_hold = 1'b0;
			next_st.w_hold = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = st.aw_sel[2] ? RESP_OKAY : RESP_SLVERR;
			if (st.w_lane && st.aw_sel == 3'h4) begin
				next_st.ext_addr = st.w_data;
			end
			if (st.w_lane && st.aw_sel == 3'h5) begin
				next_st.page = st.w_data;
			end
		end
		if (st.bvalid && S_AXI_BREADY) begin
			next_st.bvalid = 1'b0;
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end
		// Reads answer one cycle after the address is taken.
		if (st.arready && S_AXI_ARVALID) begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			unique case (decode(S_AXI_ARADDR))
				3'h4: next_st.axi_rdata = st.ext_addr;
				3'h5: next_st.axi_rdata = st.page;
				3'h6: next_st.axi_rdata = status;
				default: begin
					next_st.axi_rdata = 8'h00;
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (st.rvalid && S_AXI_RREADY) begin
			next_st.rvalid = 1'b0;
			next_st.arready = 1'b1;
		end
	end

	// State register; a low clock enable freezes everything except a synchronous reset.
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_N_IN) begin
			st <= ST_RESET;
		end else if (CE_IN) begin
			st <= next_st;
		end
	end

	// Every output is a field of the state register.
	assign CORE_RDATA_OUT = st.rdata;
	assign CORE_DONE_OUT = st.done;
	assign CORE_BUSY_OUT = st.busy;
	assign PORT3_OUT = st.p3;
	assign EMU_ACC_OUT = st.emu;
	assign MUX_DATA_BUS_OUT = st.data.o;
	assign MUX_DATA_BUS_OE_OUT = st.data.oe;
	assign LOW_ADDRESS_BUS_OUT = st.low.o;
	assign LOW_ADDRESS_BUS_OE_OUT = st.low.oe;
	assign HIGH_ADDRESS_BUS_OUT = st.high.o;
	assign HIGH_ADDRESS_BUS_OE_OUT = st.high.oe;
	assign UPPER_ADDRESS_PINS_OUT = st.upper.o;
	assign UPPER_ADDRESS_PINS_OE_OUT = st.upper.oe;
	assign S_AXI_AWREADY = st.awready;
	assign S_AXI_WREADY = st.wready;
	assign S_AXI_BRESP = st.bresp;
	assign S_AXI_BVALID = st.bvalid;
	assign S_AXI_ARREADY = st.arready;
	assign S_AXI_RDATA = {24'h0, st.axi_rdata};
	assign S_AXI_RRESP = st.rresp;
	assign S_AXI_RVALID = st.rvalid;

	// Checks on the pin behaviour.
	AST_P3_FROZEN: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(CE_IN && EMULATION_MODE_IN) |=> (PORT3_OUT == $past(PORT3_OUT)))
		else $error("port 3 moved during emulation");
	AST_EMULATION_SELECT_FLOAT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(CE_IN && EMULATION_MODE_IN && EMULATION_SELECT_IN) |=>
		(MUX_DATA_BUS_OE_OUT == 8'h00 && LOW_ADDRESS_BUS_OE_OUT == 8'h00 &&
		HIGH_ADDRESS_BUS_OE_OUT == 8'h00 && UPPER_ADDRESS_PINS_OE_OUT == 4'h0))
		else $error("pins driven with emulation select high");
	AST_RD_ONLY_DRIVE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(CE_IN && EMULATION_MODE_IN && !UPPER_ADDRESS_PINS_IN[1]) |=>
		(MUX_DATA_BUS_OE_OUT == 8'h00))
		else $error("data pins driven without read strobe");
	AST_RD_DATA: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(CE_IN && EMULATION_MODE_IN && !EMULATION_SELECT_IN &&
		UPPER_ADDRESS_PINS_IN[1]) |=> (MUX_DATA_BUS_OE_OUT == 8'hff &&
		MUX_DATA_BUS_OUT == $past(EMU_RDATA_IN)))
		else $error("emulator read data not driven");
	AST_WR_PULSE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(CE_IN && EMULATION_MODE_IN && !EMULATION_SELECT_IN &&
		UPPER_ADDRESS_PINS_IN[0] && !st.wr_q) |=> (EMU_ACC_OUT.wr &&
		EMU_ACC_OUT.addr == $past(LOW_ADDRESS_BUS_IN) &&
		EMU_ACC_OUT.target == $past(HIGH_ADDRESS_BUS_IN[0])))
		else $error("emulator write not passed to core");
	AST_ADDR_PHASE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(st.phase == PH_ADDR && !EMULATION_MODE_IN) |->
		(MUX_DATA_BUS_OE_OUT == 8'hff &&
		MUX_DATA_BUS_OUT == LOW_ADDRESS_BUS_OUT))
		else $error("address phase missing on data pins");
	AST_CS_ONEHOT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(CE_IN && !EMULATION_MODE_IN && st.phase == PH_IDLE &&
		CORE_REQ_IN.valid && !st.type_std && st.ext_addr[EXT_CS_MODE_BIT]) |=>
		(UPPER_ADDRESS_PINS_OUT == ~(4'h1 << HIGH_ADDRESS_BUS_OUT[7:6])))
		else $error("chip select not one-hot low");
	AST_EXT_ADDR: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(CE_IN && !EMULATION_MODE_IN && st.phase == PH_IDLE &&
		CORE_REQ_IN.valid && CORE_REQ_IN.kind == ACC_DPTR_RD &&
		!st.type_std && !st.ext_addr[EXT_CS_MODE_BIT]) |=>
		(UPPER_ADDRESS_PINS_OUT == $past(st.ext_addr[3:0])))
		else $error("extended address bits wrong");
	AST_STD_MASK: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(st.type_std && !EMULATION_MODE_IN && st.phase == PH_ADDR) |->
		(HIGH_ADDRESS_BUS_OE_OUT == (STD_HIGH_MASK_MAX >>
		(STD_CODE_MAX - st.rom_code))))
		else $error("standard high address width wrong");
	AST_STORE_EN: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		(CE_IN && st.type_std && !EMULATION_MODE_IN && st.phase == PH_ADDR) |=>
		(UPPER_ADDRESS_PINS_OUT[3] == 1'b0 && st.phase == PH_DATA))
		else $error("program store enable not low in data phase");

endmodule // emu_bus_port

`default_nettype wire

// ===== testbench/ext_mem_model.sv
/*
 * External program and data memory on the multiplexed low bus.
 * Assumes the bench resolves the wire level from the device's enables.
 */
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
	// Clock.
	input wire logic clk,
	// Device side of the multiplexed bus.
	input wire logic [7:0] bus_out,
	input wire logic [7:0] bus_oe,
	// Memory read data.
	output logic [7:0] rd_data
);
	logic [7:0] addr_q = 8'h00;

	// Latch the low address byte while the device drives it out.
	always @(posedge clk) begin
		if (bus_oe == 8'hff) begin
			addr_q <= bus_out;
		end
	end

	// Data is a scramble of the address, so a stale byte never matches.
	assign rd_data = addr_q ^ 8'h3c;
endmodule // ext_mem_model
`default_nettype wire

// ===== testbench/tb.sv
/*
 * Self-checking bench for the emulation memory bus port.
 * Assumes the design package and the ext_mem_model partner.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import emu_port_pkg::*;
	typedef struct packed {
		logic [7:0] d, doe, l, h, hoe;
		logic [3:0] u;
	} snap_t;
	logic clk = 0, rst_n = 0, type_n = 1, rs_hi = 0, rs_lo = 0;
	logic emu_mode = 0, emulation_select = 1, awv = 0, wv = 0, bready = 0;
	logic arv = 0, rready = 0, ri, bz;
	logic [7:0] p3_in = 0, emu_rd = 0, emu_data = 0, emu_low = 0;
	logic [7:0] emu_high = 0, awaddr = 0, araddr = 0, x, pg, w, m;
	logic [3:0] emu_up = 0;
	logic [31:0] wdata = 0, d;
	core_req_t req = '0;
	logic [7:0] d_out, d_oe, l_out, l_oe, h_out, h_oe, c_rd, p3_out;
	logic [3:0] u_out, u_oe;
	logic done, busy, awr, wr_r, bv, arr, rv;
	logic [1:0] br, rr, r;
	logic [31:0] rd;
	emu_acc_t acc;
	wire logic [7:0] mem_q;
	snap_t s0, s1;
	logic [15:0] a;
	acc_kind_t k;
	int n, i, fails = 0, checked = 0;
	integer seed = 32'hf4738d9c;

	// Clock of 8 ns.
	always #4 clk = ~clk;

	ext_mem_model u_ext_mem_model (.clk(clk), .bus_out(d_out),
		.bus_oe(d_oe), .rd_data(mem_q));

	// Each wire shows the device where it drives, else the far side.
	emu_bus_port u_emu_bus_port (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
		.CE_IN(1'b1), .TYPE_SELECT_N_IN(type_n),
		.ROM_SIZE_SEL_HI_IN(rs_hi), .ROM_SIZE_SEL_LO_IN(rs_lo),
		.EMULATION_MODE_IN(emu_mode), .EMULATION_SELECT_IN(emulation_select),
		.CORE_REQ_IN(req), .CORE_RDATA_OUT(c_rd), .CORE_DONE_OUT(done),
		.CORE_BUSY_OUT(busy), .PORT3_CORE_IN(p3_in), .PORT3_OUT(p3_out),
		.EMU_ACC_OUT(acc), .EMU_RDATA_IN(emu_rd),
		.MUX_DATA_BUS_IN((d_out & d_oe) |
			((emu_mode ? emu_data : mem_q) & ~d_oe)),
		.MUX_DATA_BUS_OUT(d_out), .MUX_DATA_BUS_OE_OUT(d_oe),
		.LOW_ADDRESS_BUS_IN((l_out & l_oe) | (emu_low & ~l_oe)),
		.LOW_ADDRESS_BUS_OUT(l_out), .LOW_ADDRESS_BUS_OE_OUT(l_oe),
		.HIGH_ADDRESS_BUS_IN((h_out & h_oe) | (emu_high & ~h_oe)),
		.HIGH_ADDRESS_BUS_OUT(h_out), .HIGH_ADDRESS_BUS_OE_OUT(h_oe),
		.UPPER_ADDRESS_PINS_IN((u_out & u_oe) | (emu_up & ~u_oe)),
		.UPPER_ADDRESS_PINS_OUT(u_out), .UPPER_ADDRESS_PINS_OE_OUT(u_oe),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr_r), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
		.S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));

	// Compare and count.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic do_reset(input logic t);
		@(posedge clk);
		rst_n <= 1'b0;
		type_n <= t;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	// Address and data go out together; each drops once taken.
	task automatic axi_wr(input logic [7:0] ad, input logic [7:0] dv,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= ad;
		wdata <= {24'h0, dv};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		// The wait ends on bvalid; only the watchdog ends a hang.
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
		end while (!bv);
		bready <= 1'b0;
		chk(br, er);
	endtask

	task automatic rd_chk(input logic [7:0] ad, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge clk);
		araddr <= ad;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rready <= 1'b0;
		d = rd;
		chk({rr, rd}, {er, ed});
	endtask

	// One core access; snapshots of the address and data phases.
	task automatic core(input acc_kind_t kk, input logic [15:0] ad,
		input logic [7:0] wd);
		@(posedge clk);
		req <= '{1'b1, kk, ad, wd};
		@(posedge clk);
		req.valid <= 1'b0;
		for (n = 0; n < 8; n++) begin
			#1;
			if (n == 0) bz = busy;
			if (n == 0) s0 = '{d_out, d_oe, l_out, h_out, h_oe, u_out};
			if (n == 1) s1 = '{d_out, d_oe, l_out, h_out, h_oe, u_out};
			if (done) break;
			@(posedge clk);
		end
	endtask

	function automatic logic [3:0] exp_up(acc_kind_t kk, logic [7:0] e,
		logic [7:0] h);
		if (e[7]) return ~(4'h1 << h[7:6]);
		if (kk inside {ACC_MOVC, ACC_DPTR_RD, ACC_DPTR_WR}) return e[3:0];
		return 4'h0;
	endfunction

	// A hang counts as a mismatch and closes the run.
	initial begin
		#200000;
		fails++;
		give_verdict();
	end

	initial begin
		do_reset(1'b1);
		rd_chk(8'h0, 32'h0, RESP_OKAY);
		rd_chk(8'h4, 32'h0, RESP_OKAY);
		// Status: select high, advanced type, idle, normal mode.
		rd_chk(8'h8, 32'h20, RESP_OKAY);
		rd_chk(8'hc, 32'h0, RESP_SLVERR);
		// Advanced type: every access kind, random address and mode.
		for (i = 0; i < 12; i++) begin
			a = 16'($random(seed));
			{x, pg, w} = 24'($random(seed));
			k = acc_kind_t'(i % 6);
			axi_wr(8'h0, x, RESP_OKAY);
			axi_wr(8'h4, pg, RESP_OKAY);
			rd_chk(8'h0, {24'h0, x}, RESP_OKAY);
			core(k, a, w);
			ri = k inside {ACC_RI_RD, ACC_RI_WR};
			chk(n, 2);
			chk({bz, s0.d, s0.doe}, {1'b1, a[7:0], 8'hff});
			chk(s0.l, a[7:0]);
			chk(s0.h, ri ? pg : a[15:8]);
			chk(s0.u, exp_up(k, x, ri ? pg : a[15:8]));
			if (k == ACC_DPTR_WR || k == ACC_RI_WR) chk(s1.d, w);
			else chk(c_rd, a[7:0] ^ 8'h3c);
		end
		// Emulation: port 3 frozen, then read and write strobes.
		p3_in <= 8'h5a;
		repeat (2) @(posedge clk);
		emu_mode <= 1'b1;
		emulation_select <= 1'b0;
		repeat (2) @(posedge clk);
		p3_in <= 8'ha5;
		repeat (2) @(posedge clk);
		chk(p3_out, 8'h5a);
		chk({l_oe, h_oe[0], u_oe[1:0]}, 11'h0);
		for (i = 0; i < 4; i++) begin
			a = 16'($random(seed));
			emu_low <= a[7:0];
			emu_high <= {7'h0, i[0]};
			emu_data <= a[15:8];
			emu_rd <= ~a[7:0];
			emu_up <= i[1] ? 4'h1 : 4'h2;
			for (n = 0; n < 5; n++) begin
				@(posedge clk);
				#1;
				if (acc.rd || acc.wr) break;
			end
			chk({acc.wr, acc.rd, acc.target, acc.addr},
				{i[1], ~i[1], i[0], a[7:0]});
			if (i[1]) chk(acc.wdata, a[15:8]);
			else chk({d_oe, d_out}, {8'hff, ~a[7:0]});
			@(posedge clk);
			emu_up <= 4'h0;
			repeat (3) @(posedge clk);
			chk(d_oe, 8'h0);
		end
		emulation_select <= 1'b1;
		repeat (3) @(posedge clk);
		chk({d_oe, l_oe, h_oe, u_oe}, 28'h0);
		emu_mode <= 1'b0;
		// Standard type: every ROM code, inside and beyond its size.
		do_reset(1'b0);
		// Status: select high, standard type, code 00, normal mode.
		rd_chk(8'h8, 32'h22, RESP_OKAY);
		for (i = 0; i < 8; i++) begin
			{rs_hi, rs_lo} <= i[1:0];
			m = (8'h10 << i[1:0]) - 8'h1;
			a = 16'($random(seed)) & {m, 8'hff};
			if (i > 3) a = {m + 8'h1, 8'h00};
			core(i[2] ? ACC_MOVC : ACC_FETCH, a, 8'h0);
			if (i > 3) begin
				chk({n[3:0], c_rd, 2'h0, bz, s0.u[2]}, 16'h0001);
			end else begin
				chk(n, 2);
				chk(s0.l, a[7:0]);
				chk({s0.hoe, s0.h & m}, {m, a[15:8]});
				chk({bz, s0.u[2], s1.u[3]}, 3'h4);
				chk(c_rd, a[7:0] ^ 8'h3c);
			end
		end
		give_verdict();
	end
endmodule // tb
`default_nettype wire
